// file: fpec_map.svh
`ifndef FPEC_MAP_SVH
`define FPEC_MAP_SVH
`define FPEC_ADDR_MODE_CTRL 16'hff80
`define FPEC_ADDR_SETUP_CTRL 16'hff81
`define FPEC_ADDR_EBLK_HI 16'hff82
`define FPEC_ADDR_EBLK_LO 16'hff83
`define FPEC_ADDR_SERIAL_TIMER_CONTROL 16'hffc3
`define FPEC_RST_MODE_CTRL 8'h80
`define FPEC_RST_ZERO 8'h00
`define FPEC_BIT_HWE 7
`define FPEC_BIT_SWE 6
`define FPEC_BIT_EV 3
`define FPEC_BIT_PV 2
`define FPEC_BIT_ERASE 1
`define FPEC_BIT_PROG 0
`define FPEC_BIT_ESU 1
`define FPEC_BIT_PSU 0
`define FPEC_BIT_FLSEL 3
`define FPEC_EBLK_HI_MASK 8'h03
`define FPEC_UNDEF_READ 8'hff
`define FPEC_ACC_STATES 2'd2
`endif

// file: fpec_pkg.sv
package fpec_pkg;
	typedef enum logic [2:0] {
		FPEC_MODE_USER = 3'b000,
		FPEC_MODE_USER_PROG = 3'b001,
		FPEC_MODE_BOOT = 3'b010,
		FPEC_MODE_WRITER = 3'b011,
		FPEC_MODE_ROM_OFF = 3'b100
	} fpec_opmode_t;
	typedef enum logic [1:0] {
		FPEC_BUS_IDLE = 2'b00,
		FPEC_BUS_WAIT = 2'b01,
		FPEC_BUS_DONE = 2'b10
	} fpec_bus_t;
endpackage

// file: fpec_mode_strap.sv
`timescale 1ns/1ps
// Captures the operating mode from synchronised pins on every cycle of reset and holds it after release.
module fpec_mode_strap (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic [1:0] mode_pins_in,
	input wire logic [2:0] boot_pins_in,
	output fpec_pkg::fpec_opmode_t opmode_out
);
	logic [4:0] sync1_reg;
	logic [4:0] sync2_reg;
	fpec_pkg::fpec_opmode_t opmode_reg;
	fpec_pkg::fpec_opmode_t opmode_next;

	always_comb begin
		opmode_next = opmode_reg;
		if (srst_in) begin
			if (sync2_reg[4:3] == 2'b00) begin
				// Boot pins only matter with both mode pins low.  // see RQ4
				unique case (sync2_reg[2:0])
					3'b000: opmode_next = fpec_pkg::FPEC_MODE_WRITER;
					3'b001: opmode_next = fpec_pkg::FPEC_MODE_BOOT;
					3'b010: opmode_next = fpec_pkg::FPEC_MODE_USER_PROG;
					default: opmode_next = fpec_pkg::FPEC_MODE_USER;
				endcase
			end else if (sync2_reg[4:3] == 2'b01) begin
				opmode_next = fpec_pkg::FPEC_MODE_ROM_OFF;
			end else begin
				opmode_next = fpec_pkg::FPEC_MODE_USER;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		sync1_reg <= {mode_pins_in, boot_pins_in};
		sync2_reg <= sync1_reg;
		opmode_reg <= opmode_next;
	end

	assign opmode_out = opmode_reg;
endmodule

// file: fpec_top.sv
`timescale 1ns/1ps
`include "fpec_map.svh"
// Overview of operation
// RQ1: User mode reads flash, refuses program/erase.
// RQ2: Program/erase only in boot, user-program, writer.
// RQ3: Erase blocks: 4x1k,28k,16k,2x8k,2x32k large.
// RQ4: Boot pins sampled only when mode pins low.
// RQ5: Flash registers reachable only with select bit set.
// RQ6: Four registers at FF80-FF83, shared addresses.
// RQ7: Flash disabled: reads 00, writes ignored.
// RQ8: Write enable clear holds setup, blocks at 00.
// RQ9: Byte accesses only, two bus states each.
// RQ10: Mask-ROM variant: undefined reads, ignored writes.
// RQ11: Mode register resets to 80 in standby modes.
// RQ12: Verify bits writable only with write enable.
// RQ13: Erase bit needs write enable and erase setup.
// RQ14: Program bit needs write enable and program setup.
// RQ15: Software: enable, program setup, program, separately.
// RQ16: Software: enable, erase setup, erase, separately.
// RQ17: Hardware write enable flag reads 1 always.
// RQ18: Software sets write enable first, clears separately.
// RQ19: Mode register bits 5,4 read zero.
// RQ20: Bits 3..0 select EV, PV, erase, program.
// RQ21: Software never sets mode bit with others.
// RQ22: Setup register: erase bit1, program bit0, need enable.
// RQ23: Clearing select bit keeps register contents.
// RQ24: At most one operation driven to array.
module fpec_top #(
	parameter bit LARGE_VERSION = 1'b1,
	parameter bit MASK_ROM = 1'b0
) (
	input wire logic REF_CLK_IN,
	input wire logic SRST_IN,
	input wire logic STANDBY_IN,
	input wire logic [1:0] MODE_PINS_IN,
	input wire logic [2:0] BOOT_SELECT_PINS_IN,
	input wire logic [15:0] BUS_ADDR_IN,
	input wire logic BUS_REQ_IN,
	input wire logic BUS_WRITE_IN,
	input wire logic BUS_BYTE_IN,
	input wire logic [7:0] BUS_WDATA_IN,
	output logic [7:0] BUS_RDATA_OUT,
	output logic BUS_ACK_OUT,
	output logic BUS_HIT_OUT,
	output logic FLASH_PROG_OUT,
	output logic FLASH_ERASE_OUT,
	output logic FLASH_PVERIFY_OUT,
	output logic FLASH_EVERIFY_OUT,
	output logic [9:0] FLASH_ERASE_BLOCKS_OUT,
	output logic [2:0] OPMODE_OUT
);
	fpec_pkg::fpec_opmode_t opmode;
	logic flash_on;
	logic prog_allowed;

	fpec_mode_strap u_strap (
		.clk_in(REF_CLK_IN),
		.srst_in(SRST_IN),
		.mode_pins_in(MODE_PINS_IN),
		.boot_pins_in(BOOT_SELECT_PINS_IN),
		.opmode_out(opmode)
	);

	// Flash array is off when mode disables on-chip ROM or the part is mask ROM.
	assign flash_on = (opmode != fpec_pkg::FPEC_MODE_ROM_OFF) && !MASK_ROM;
	assign prog_allowed = (opmode == fpec_pkg::FPEC_MODE_BOOT) || // see RQ2
		(opmode == fpec_pkg::FPEC_MODE_USER_PROG) ||
		(opmode == fpec_pkg::FPEC_MODE_WRITER);

	////////////////////////////////////////////////////////////////////////////////
	// Bus handshake: each byte access takes two states.

	fpec_pkg::fpec_bus_t bus_reg;
	fpec_pkg::fpec_bus_t bus_next;
	logic [15:0] addr_reg;
	logic [15:0] addr_next;
	logic wr_reg;
	logic wr_next;
	logic byte_reg;
	logic byte_next;
	logic [7:0] wdata_reg;
	logic [7:0] wdata_next;
	logic do_access;

	always_comb begin
		bus_next = bus_reg;
		addr_next = addr_reg;
		wr_next = wr_reg;
		byte_next = byte_reg;
		wdata_next = wdata_reg;
		unique case (bus_reg)
			fpec_pkg::FPEC_BUS_IDLE: begin
				if (BUS_REQ_IN) begin
					bus_next = fpec_pkg::FPEC_BUS_WAIT; // see RQ9
					addr_next = BUS_ADDR_IN;
					wr_next = BUS_WRITE_IN;
					byte_next = BUS_BYTE_IN;
					wdata_next = BUS_WDATA_IN;
				end
			end
			fpec_pkg::FPEC_BUS_WAIT: bus_next = fpec_pkg::FPEC_BUS_DONE;
			default: bus_next = fpec_pkg::FPEC_BUS_IDLE;
		endcase
		if (SRST_IN) begin
			bus_next = fpec_pkg::FPEC_BUS_IDLE;
			addr_next = 16'h0000;
			wr_next = 1'b0;
			byte_next = 1'b0;
			wdata_next = 8'h00;
		end
	end

	always_ff @(posedge REF_CLK_IN) begin
		bus_reg <= bus_next;
		addr_reg <= addr_next;
		wr_reg <= wr_next;
		byte_reg <= byte_next;
		wdata_reg <= wdata_next;
	end

	assign do_access = (bus_reg == fpec_pkg::FPEC_BUS_WAIT);

	////////////////////////////////////////////////////////////////////////////////
	// Register file.

	logic [7:0] serial_timer_control_reg;
	logic [7:0] serial_timer_control_next;
	logic [7:0] mode_ctrl_reg;
	logic [7:0] mode_ctrl_next;
	logic [7:0] setup_reg;
	logic [7:0] setup_next;
	logic [7:0] eblk_hi_reg;
	logic [7:0] eblk_hi_next;
	logic [7:0] eblk_lo_reg;
	logic [7:0] eblk_lo_next;
	logic sel;
	logic in_flash_win;
	logic fl_wr;
	logic sw_write_enable;
	logic [7:0] d;

	assign sel = serial_timer_control_reg[`FPEC_BIT_FLSEL];
	// Word accesses are not decoded in the flash window.
	assign in_flash_win = (addr_reg[15:2] == 14'(`FPEC_ADDR_MODE_CTRL >> 2)) && sel && byte_reg; // see RQ5
	assign fl_wr = do_access && wr_reg && in_flash_win && flash_on; // see RQ7
	assign sw_write_enable = mode_ctrl_reg[`FPEC_BIT_SWE];
	assign d = wdata_reg;

	always_comb begin
		serial_timer_control_next = serial_timer_control_reg;
		mode_ctrl_next = mode_ctrl_reg;
		setup_next = setup_reg;
		eblk_hi_next = eblk_hi_reg;
		eblk_lo_next = eblk_lo_reg;
		if (do_access && wr_reg && addr_reg == `FPEC_ADDR_SERIAL_TIMER_CONTROL) begin
			serial_timer_control_next = d; // see RQ23
		end
		if (fl_wr) begin
			unique case (addr_reg[1:0])
				2'b00: begin
					mode_ctrl_next[`FPEC_BIT_SWE] = d[`FPEC_BIT_SWE];
					if (sw_write_enable) begin
						mode_ctrl_next[`FPEC_BIT_EV] = d[`FPEC_BIT_EV]; // see RQ12
						mode_ctrl_next[`FPEC_BIT_PV] = d[`FPEC_BIT_PV]; // see RQ20
					end
					if (sw_write_enable && setup_reg[`FPEC_BIT_ESU]) begin
						mode_ctrl_next[`FPEC_BIT_ERASE] = d[`FPEC_BIT_ERASE]; // see RQ13
					end
					if (sw_write_enable && setup_reg[`FPEC_BIT_PSU]) begin
						mode_ctrl_next[`FPEC_BIT_PROG] = d[`FPEC_BIT_PROG]; // see RQ14
					end
				end
				2'b01: begin
					if (sw_write_enable) begin
						setup_next[`FPEC_BIT_ESU] = d[`FPEC_BIT_ESU]; // see RQ22
						setup_next[`FPEC_BIT_PSU] = d[`FPEC_BIT_PSU];
					end
				end
				2'b10: begin
					if (sw_write_enable && LARGE_VERSION) begin
						eblk_hi_next = d & `FPEC_EBLK_HI_MASK; // see RQ3
					end
				end
				default: begin
					if (sw_write_enable) begin
						eblk_lo_next = d;
					end
				end
			endcase
		end
		// Mode bits are forced to zero without the software enable.
		if (!mode_ctrl_next[`FPEC_BIT_SWE]) begin
			setup_next = `FPEC_RST_ZERO; // see RQ8
			eblk_hi_next = `FPEC_RST_ZERO;
			eblk_lo_next = `FPEC_RST_ZERO;
			mode_ctrl_next[3:0] = 4'h0;
		end
		mode_ctrl_next[`FPEC_BIT_HWE] = 1'b1; // see RQ17
		mode_ctrl_next[5:4] = 2'b00; // see RQ19
		setup_next[7:2] = 6'h00;
		if (SRST_IN || STANDBY_IN) begin
			mode_ctrl_next = `FPEC_RST_MODE_CTRL; // see RQ11
			setup_next = `FPEC_RST_ZERO;
			eblk_hi_next = `FPEC_RST_ZERO;
			eblk_lo_next = `FPEC_RST_ZERO;
		end
		if (SRST_IN) begin
			serial_timer_control_next = `FPEC_RST_ZERO;
		end
	end

	always_ff @(posedge REF_CLK_IN) begin
		serial_timer_control_reg <= serial_timer_control_next;
		mode_ctrl_reg <= mode_ctrl_next;
		setup_reg <= setup_next;
		eblk_hi_reg <= eblk_hi_next;
		eblk_lo_reg <= eblk_lo_next;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read path and array strobes.

	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic ack_reg;
	logic ack_next;
	logic hit_reg;
	logic hit_next;
	logic [3:0] op_reg;
	logic [3:0] op_next;
	logic [9:0] blk_reg;
	logic [9:0] blk_next;
	logic [3:0] req_ops;

	always_comb begin
		rdata_next = rdata_reg;
		hit_next = 1'b0;
		ack_next = do_access;
		if (do_access && !wr_reg) begin
			rdata_next = 8'h00;
			if (addr_reg == `FPEC_ADDR_SERIAL_TIMER_CONTROL) begin
				rdata_next = serial_timer_control_reg;
				hit_next = 1'b1;
			end else if (in_flash_win) begin
				hit_next = 1'b1;
				if (MASK_ROM) begin
					rdata_next = `FPEC_UNDEF_READ; // see RQ10
				end else if (!flash_on) begin
					rdata_next = 8'h00; // see RQ7
				end else begin
					unique case (addr_reg[1:0]) // see RQ6
						2'b00: rdata_next = mode_ctrl_reg;
						2'b01: rdata_next = setup_reg;
						2'b10: rdata_next = eblk_hi_reg;
						default: rdata_next = eblk_lo_reg;
					endcase
				end
			end
		end else if (do_access) begin
			hit_next = (addr_reg == `FPEC_ADDR_SERIAL_TIMER_CONTROL) || in_flash_win;
		end
		if (SRST_IN) begin
			rdata_next = 8'h00;
			ack_next = 1'b0;
			hit_next = 1'b0;
		end
	end

	// Priority keeps a single operation even if software set several bits.
	assign req_ops = (flash_on && prog_allowed) ? mode_ctrl_reg[3:0] : 4'h0; // see RQ1

	always_comb begin
		op_next = 4'h0;
		if (req_ops[`FPEC_BIT_PROG]) begin
			op_next = 4'h1; // see RQ24
		end else if (req_ops[`FPEC_BIT_ERASE]) begin
			op_next = 4'h2;
		end else if (req_ops[`FPEC_BIT_PV]) begin
			op_next = 4'h4;
		end else if (req_ops[`FPEC_BIT_EV]) begin
			op_next = 4'h8;
		end
		blk_next = {eblk_hi_reg[1:0], eblk_lo_reg};
		if (SRST_IN) begin
			op_next = 4'h0;
			blk_next = 10'h000;
		end
	end

	always_ff @(posedge REF_CLK_IN) begin
		rdata_reg <= rdata_next;
		ack_reg <= ack_next;
		hit_reg <= hit_next;
		op_reg <= op_next;
		blk_reg <= blk_next;
	end

	assign BUS_RDATA_OUT = rdata_reg;
	assign BUS_ACK_OUT = ack_reg;
	assign BUS_HIT_OUT = hit_reg;
	assign FLASH_PROG_OUT = op_reg[0];
	assign FLASH_ERASE_OUT = op_reg[1];
	assign FLASH_PVERIFY_OUT = op_reg[2];
	assign FLASH_EVERIFY_OUT = op_reg[3];
	assign FLASH_ERASE_BLOCKS_OUT = blk_reg;
	assign OPMODE_OUT = opmode;
endmodule

// file: fpec_top_checker.sv
`timescale 1ns/1ps
module fpec_top_checker #(
	parameter bit MASK_ROM = 1'b0
) (
	input wire logic REF_CLK_IN,
	input wire logic SRST_IN,
	input wire logic [15:0] BUS_ADDR_IN,
	input wire logic BUS_REQ_IN,
	input wire logic BUS_WRITE_IN,
	input wire logic [7:0] BUS_RDATA_OUT,
	input wire logic BUS_ACK_OUT,
	input wire logic BUS_HIT_OUT,
	input wire logic FLASH_PROG_OUT,
	input wire logic FLASH_ERASE_OUT,
	input wire logic FLASH_PVERIFY_OUT,
	input wire logic FLASH_EVERIFY_OUT,
	input wire logic [9:0] FLASH_ERASE_BLOCKS_OUT,
	input wire logic [2:0] OPMODE_OUT
);
	logic [1:0] wait_reg;
	logic [1:0] wait_next;
	logic take;
	logic fl_rd;
	logic [3:0] strb;
	assign take = BUS_REQ_IN && (wait_reg == 2'h0);
	assign fl_rd = take && !BUS_WRITE_IN && (BUS_ADDR_IN[15:2] == 14'h3fe0);
	assign strb = {FLASH_PROG_OUT, FLASH_ERASE_OUT, FLASH_PVERIFY_OUT, FLASH_EVERIFY_OUT};
	// Shadow of the bus busy window, so a request is only counted when the block takes it.
	always_comb begin
		wait_next = take ? 2'h2 : ((wait_reg == 2'h0) ? 2'h0 : wait_reg - 2'h1);
		if (SRST_IN) begin
			wait_next = 2'h0;
		end
	end
	always_ff @(posedge REF_CLK_IN) begin
		wait_reg <= wait_next;
	end
	default clocking cb @(posedge REF_CLK_IN); endclocking
	default disable iff (SRST_IN);
	ack_latency_a: assert property (take |-> ##2 BUS_ACK_OUT) else $error("ack late");
	ack_cause_a: assert property (BUS_ACK_OUT |-> $past(take, 2)) else $error("stray ack");
	ack_spacing_a: assert property (BUS_ACK_OUT |=> !BUS_ACK_OUT [*2]) else $error("ack spacing");
	hit_with_ack_a: assert property (BUS_HIT_OUT |-> BUS_ACK_OUT) else $error("hit alone");
	one_strobe_a: assert property ($onehot0(strb)) else $error("two strobes");
	strobe_mode_a: assert property ((FLASH_PROG_OUT || FLASH_ERASE_OUT) |->
		OPMODE_OUT inside {3'h1, 3'h2, 3'h3}) else $error("bad mode");
	strobe_after_write_a: assert property ($rose(|strb) |->
		($past(BUS_ACK_OUT) || $past(BUS_ACK_OUT, 2))) else $error("strobe cause");
	hwe_read_a: assert property (BUS_ACK_OUT && BUS_HIT_OUT &&
		$past(fl_rd, 2) && !MASK_ROM && $past(BUS_ADDR_IN, 2) == 16'hff80 &&
		OPMODE_OUT != 3'h4 |-> BUS_RDATA_OUT[7] && BUS_RDATA_OUT[5:4] == 2'h0)
		else $error("mode read");
	rom_off_read_a: assert property (BUS_ACK_OUT && BUS_HIT_OUT &&
		$past(fl_rd, 2) && !MASK_ROM && OPMODE_OUT == 3'h4 |-> BUS_RDATA_OUT == 8'h00)
		else $error("off read");
	reset_clear_a: assert property (disable iff (1'b0) SRST_IN |=>
		!BUS_ACK_OUT && strb == 4'h0 && FLASH_ERASE_BLOCKS_OUT == 10'h000)
		else $error("reset state");
	prog_cov: cover property ($rose(FLASH_PROG_OUT));
	erase_cov: cover property ($rose(FLASH_ERASE_OUT));
	hit_cov: cover property (BUS_ACK_OUT && BUS_HIT_OUT);
endmodule
bind fpec_top fpec_top_checker #(.MASK_ROM(MASK_ROM)) fpec_top_checker_i (.*);

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic REF_CLK_IN = 1'b0;
	logic SRST_IN = 1'b1;
	logic STANDBY_IN = 1'b0;
	logic [1:0] MODE_PINS_IN = 2'h0;
	logic [2:0] BOOT_SELECT_PINS_IN = 3'h2;
	logic [15:0] BUS_ADDR_IN = 16'h0000;
	logic BUS_REQ_IN = 1'b0;
	logic BUS_WRITE_IN = 1'b0;
	logic BUS_BYTE_IN = 1'b1;
	logic [7:0] BUS_WDATA_IN = 8'h00;
	logic [7:0] BUS_RDATA_OUT;
	logic BUS_ACK_OUT;
	logic BUS_HIT_OUT;
	logic FLASH_PROG_OUT, FLASH_ERASE_OUT, FLASH_PVERIFY_OUT, FLASH_EVERIFY_OUT;
	logic [9:0] FLASH_ERASE_BLOCKS_OUT;
	logic [2:0] OPMODE_OUT;
	int bad_count = 0;
	int num_checks = 0;
	integer seed = 22;
	logic [7:0] rd, d;
	logic hit;
	logic [1:0] mp [6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h1};
	logic [2:0] bp [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h0, 3'h0};
	logic [2:0] om [6] = '{3'h3, 3'h2, 3'h1, 3'h0, 3'h0, 3'h4};
	fpec_top fpec_top_i (.*);
	initial begin
		forever #2 REF_CLK_IN = ~REF_CLK_IN;
	end
	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	// The request is held until the rising edge after the falling edge that samples the answer, then dropped.
	task automatic bus(input logic [15:0] a, input logic w, input logic [7:0] wd);
		int n;
		n = 0;
		@(posedge REF_CLK_IN);
		BUS_REQ_IN <= 1'b1;
		BUS_ADDR_IN <= a;
		BUS_WRITE_IN <= w;
		BUS_WDATA_IN <= wd;
		do begin
			@(negedge REF_CLK_IN);
			n++;
		end while (BUS_ACK_OUT !== 1'b1 && n < 8);
		if (n >= 8) begin
			bad_count++;
			test_done();
		end else begin
			rd = BUS_RDATA_OUT;
			hit = BUS_HIT_OUT;
			@(posedge REF_CLK_IN);
			BUS_REQ_IN <= 1'b0;
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] wd);
		bus(a, 1'b1, wd);
	endtask
	task automatic rdc(input string n, input logic [15:0] a, input logic [7:0] e);
		bus(a, 1'b0, 8'h00);
		chk(n, {2'h0, e}, {2'h0, rd});
	endtask
	task automatic rst(input logic [1:0] m, input logic [2:0] b);
		@(posedge REF_CLK_IN);
		SRST_IN <= 1'b1;
		MODE_PINS_IN <= m;
		BOOT_SELECT_PINS_IN <= b;
		repeat (20) @(posedge REF_CLK_IN);
		SRST_IN <= 1'b0;
		wr(16'hffc3, 8'h08);
	endtask
	initial begin
		rst(2'h0, 3'h2);
		chk("opmode", 10'h1, {7'h0, OPMODE_OUT});
		rdc("mode", 16'hff80, 8'h80);
		rdc("setup", 16'hff81, 8'h00);
		wr(16'hff81, 8'h03);
		rdc("setup", 16'hff81, 8'h00);
		wr(16'hff80, 8'h0c);
		rdc("mode", 16'hff80, 8'h80);
		wr(16'hff80, 8'h70);
		rdc("mode", 16'hff80, 8'hc0);
		wr(16'hff80, 8'h42);
		rdc("mode", 16'hff80, 8'hc0);
		wr(16'hff80, 8'h41);
		rdc("mode", 16'hff80, 8'hc0);
		wr(16'hff80, 8'h44);
		rdc("mode", 16'hff80, 8'hc4);
		chk("pverify", 10'h1, 10'(FLASH_PVERIFY_OUT));
		wr(16'hff80, 8'h40);
		wr(16'hff81, 8'h01);
		rdc("setup", 16'hff81, 8'h01);
		wr(16'hff80, 8'h41);
		repeat (3) @(posedge REF_CLK_IN);
		chk("prog", 10'h1, 10'(FLASH_PROG_OUT));
		wr(16'hff80, 8'h40);
		wr(16'hff81, 8'h02);
		wr(16'hff80, 8'h42);
		repeat (3) @(posedge REF_CLK_IN);
		chk("erase", 10'h1, 10'(FLASH_ERASE_OUT));
		wr(16'hff80, 8'h40);
		wr(16'hff80, 8'h48);
		repeat (3) @(posedge REF_CLK_IN);
		chk("everify", 10'h1, 10'(FLASH_EVERIFY_OUT));
		chk("erase_off", 10'h0, 10'(FLASH_ERASE_OUT));
		wr(16'hff80, 8'h40);
		for (int i = 0; i < 6; i++) begin
			d = 8'($random(seed));
			wr(16'hff83, d);
			wr(16'hff82, d);
			rdc("blk_hi", 16'hff82, d & 8'h03);
			chk("blocks", {d[1:0], d}, FLASH_ERASE_BLOCKS_OUT);
			bus({9'h1fe, d[6:0]}, 1'b0, 8'h00);
			chk("unmapped", 10'h0, 10'(hit));
		end
		wr(16'hffc3, 8'h00);
		bus(16'hff83, 1'b0, 8'h00);
		chk("desel", 10'h0, 10'(hit));
		wr(16'hffc3, 8'h08);
		rdc("blk_lo", 16'hff83, d);
		BUS_BYTE_IN <= 1'b0;
		bus(16'hff83, 1'b1, 8'h55);
		chk("word_hit", 10'h0, 10'(hit));
		BUS_BYTE_IN <= 1'b1;
		rdc("blk_lo", 16'hff83, d);
		@(posedge REF_CLK_IN);
		STANDBY_IN <= 1'b1;
		repeat (4) @(posedge REF_CLK_IN);
		STANDBY_IN <= 1'b0;
		rdc("mode", 16'hff80, 8'h80);
		rdc("blk_lo", 16'hff83, 8'h00);
		wr(16'hff80, 8'h40);
		wr(16'hff83, 8'h01);
		wr(16'hff80, 8'h00);
		rdc("blk_lo", 16'hff83, 8'h00);
		for (int i = 0; i < 6; i++) begin
			rst(mp[i], bp[i]);
			chk("opmode", {7'h0, om[i]}, {7'h0, OPMODE_OUT});
			wr(16'hff80, 8'h40);
			wr(16'hff81, 8'h01);
			wr(16'hff80, 8'h41);
			repeat (3) @(posedge REF_CLK_IN);
			chk("prog", 10'(om[i] inside {3'h1, 3'h2, 3'h3}), 10'(FLASH_PROG_OUT));
			if (om[i] == 3'h4) begin
				rdc("mode", 16'hff80, 8'h00);
			end
		end
		test_done();
	end
endmodule
